// >>> src/gim_counter.sv
// Gate interval measurement counter channel with capture FIFO and stream.
// Assumes window, tick and sample pins are asynchronous to core_clk_i,
// configuration inputs are steady while armed, ticks below MAX_TICK_HZ.
//
// Overview of operation
// - Width mode polarity selects high or low pulses
// - Count selected tick edges while pulse active
// - Armed mid-pulse waits for next active entry
// - Single width pushes once then ignores edges
// - Implicit width pushes on every trailing edge
// - Buffered captures stream out to host memory
// - Sampled width pushes last completed width
// - Missing pulse between sample edges flags overrun
// - Pulse mode counts ticks of both phases
// - Implicit pulse captures a high/low pair at every second window edge
// - Implicit pulse starts at chosen first edge
// - Sampled pulse pushes last high/low pair
// - Semi-period counts ticks between consecutive edges
// - Implicit semi pushes each edge, phase selectable
// - Single semi-period behaves as single width
// - Shared capture: pulse paired, semi separate
// - No sampled timing for semi-period mode
// - Period mode counts reference over one period
// - 32-bit counter, window pin resynchronised first
module gim_counter
    import gim_pkg::*;
(
    input logic core_clk_i,
    input logic rst_i,
    input logic window_i,
    input logic ref_tick_i,
    input logic sample_clk_i,
    input logic arm_i,
    input logic disarm_i,
    input gim_meas_t measure_mode_i,
    input gim_timing_t timing_mode_i,
    input logic window_active_low_i,
    input logic tick_falling_i,
    input logic sample_falling_i,
    input logic first_phase_select_i,
    input logic first_interval_phase_select_i,
    input logic clear_errors_i,
    input logic stream_ready_i,
    output logic stream_valid_o,
    output logic [SMP_W-1:0] stream_data_o,
    output logic [CNT_W-1:0] count_o,
    output logic armed_o,
    output logic done_o,
    output logic overrun_o,
    output logic overflow_o,
    output logic cfg_err_o
);
    // All channel state
    typedef struct packed {
        logic [PIN_N-1:0] sync1;   // First synchroniser stage
        logic [PIN_N-1:0] sync2;   // Second synchroniser stage
        logic [PIN_N-1:0] prev;    // Edge detect history
        gim_state_t st;            // Sequencer state
        logic [CNT_W-1:0] cnt;     // Interval counter
        logic [CNT_W-1:0] half;    // First phase of a pair
        logic half_have;           // First phase held
        logic half_high;           // Held phase was high
        logic [SMP_W-1:0] last;    // Latest completed capture
        logic have_new;            // Capture since last sample
        logic overrun;             // Sample without fresh pulse
        logic overflow;            // Capture lost on full FIFO
        logic cfg_err;             // Refused arm request
        logic armed;               // Registered WAIT or MEAS decode
        logic done;                // Registered finished decode
        logic out_valid;           // Stream word held
        logic [SMP_W-1:0] out_data;
    } gim_core_t;

    gim_core_t s_reg;
    gim_core_t s_next;

    // Synchronised pins and edge events
    logic win, win_rise, win_fall, win_edge;
    logic act, enter_act, leave_act, tick_evt, smp_evt;
    logic tick_now, tick_old, smp_now, smp_old;
    // Mode decode
    gim_meas_t eff_meas;
    logic sampled, single, start_edge, end_edge, bad_cfg;
    // Capture and FIFO traffic
    logic cap_v, push_v, fifo_wr_ready, fifo_rd_valid, fifo_rd_ready;
    logic [SMP_W-1:0] cap_d, push_d, fifo_rd_data;

    // Edge detection only on the second stage and its history
    assign win = s_reg.sync2[PIN_WIN];
    assign win_rise = win && !s_reg.prev[PIN_WIN];
    assign win_fall = !win && s_reg.prev[PIN_WIN];
    assign win_edge = win_rise || win_fall;
    assign act = win ^ window_active_low_i;
    assign enter_act = window_active_low_i ? win_fall : win_rise;
    assign leave_act = window_active_low_i ? win_rise : win_fall;
    assign tick_now = s_reg.sync2[PIN_TICK];
    assign tick_old = s_reg.prev[PIN_TICK];
    assign smp_now = s_reg.sync2[PIN_SMP];
    assign smp_old = s_reg.prev[PIN_SMP];
    // Selected reference tick edge
    assign tick_evt = tick_falling_i ? (tick_old && !tick_now)
                                     : (tick_now && !tick_old);
    // Selected sample clock edge
    assign smp_evt = sample_falling_i ? (smp_old && !smp_now)
                                      : (smp_now && !smp_old);

    // Single semi-period is the single width measurement
    assign eff_meas = (measure_mode_i == MEAS_SEMI &&
                       timing_mode_i == TIM_SINGLE) ? MEAS_WIDTH
                                                    : measure_mode_i;
    assign sampled = (timing_mode_i == TIM_SAMPLED);
    assign single = (timing_mode_i == TIM_SINGLE);
    // Semi-period has no sampled delivery
    assign bad_cfg = (measure_mode_i == MEAS_SEMI) && sampled;

    // Edge that opens the first interval after arming
    always_comb begin
        case (eff_meas)
            MEAS_PULSE: start_edge = first_phase_select_i ? win_rise
                                                          : win_fall;
            MEAS_SEMI: start_edge = first_interval_phase_select_i
                                    ? win_rise : win_fall;
            default: start_edge = enter_act;
        endcase
    end

    // Edge that closes the running interval
    always_comb begin
        case (eff_meas)
            MEAS_WIDTH: end_edge = leave_act;
            MEAS_PERIOD: end_edge = enter_act;
            default: end_edge = win_edge;
        endcase
    end

    // Capture FIFO
    gim_fifo u_fifo (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .wr_valid_i(push_v),
        .wr_data_i(push_d),
        .wr_ready_o(fifo_wr_ready),
        .rd_valid_o(fifo_rd_valid),
        .rd_data_o(fifo_rd_data),
        .rd_ready_i(fifo_rd_ready)
    );

    // Output register takes a word when empty or being drained
    assign fifo_rd_ready = !s_reg.out_valid || stream_ready_i;

    // Sequencer, counter, capture and stream next state
    always_comb begin
        s_next = s_reg;
        cap_v = 1'b0;
        cap_d = '0;
        push_v = 1'b0;
        push_d = '0;
        // Two flops before anything reads a pin
        s_next.sync1[PIN_WIN] = window_i;
        s_next.sync1[PIN_TICK] = ref_tick_i;
        s_next.sync1[PIN_SMP] = sample_clk_i;
        s_next.sync2 = s_reg.sync1;
        s_next.prev = s_reg.sync2;
        // Software clear first so hardware sets win
        if (clear_errors_i) begin
            s_next.overrun = 1'b0;
            s_next.overflow = 1'b0;
            s_next.cfg_err = 1'b0;
        end
        // Count ticks inside an interval; width only while active
        if (s_reg.st == ST_MEAS && tick_evt &&
            (eff_meas != MEAS_WIDTH || act)) begin
            s_next.cnt = s_reg.cnt + CNT_W'(1);
        end
        case (s_reg.st)
            // Idle or finished: wait for arming
            ST_IDLE, ST_DONE: begin
                if (arm_i && bad_cfg) begin
                    s_next.cfg_err = 1'b1;
                end else if (arm_i) begin
                    s_next.st = ST_WAIT;
                    s_next.half_have = 1'b0;
                    s_next.have_new = 1'b0;
                end
            end
            // Armed: a level alone never starts counting
            ST_WAIT: begin
                if (start_edge) begin
                    s_next.cnt = '0;
                    s_next.half_have = 1'b0;
                    s_next.st = ST_MEAS;
                end
            end
            // Counting: close interval on its end edge
            ST_MEAS: begin
                if (end_edge) begin
                    s_next.cnt = '0;
                    if (eff_meas == MEAS_PULSE) begin
                        if (!s_reg.half_have) begin
                            // Hold first phase; low window now means high
                            s_next.half = s_reg.cnt;
                            s_next.half_high = !win;
                            s_next.half_have = 1'b1;
                        end else begin
                            // Pair as one sample, high above low
                            s_next.half_have = 1'b0;
                            cap_v = 1'b1;
                            cap_d[SMP_PAIR_BIT] = 1'b1;
                            cap_d[SMP_PAIR_BIT-1:SMP_HI_LSB] =
                                s_reg.half_high ? s_reg.half : s_reg.cnt;
                            cap_d[CNT_W-1:0] =
                                s_reg.half_high ? s_reg.cnt : s_reg.half;
                        end
                    end else begin
                        // One interval per sample
                        cap_v = 1'b1;
                        cap_d[CNT_W-1:0] = s_reg.cnt;
                    end
                    // Width re-arms for the next active entry
                    if (eff_meas == MEAS_WIDTH) begin
                        s_next.st = ST_WAIT;
                    end
                    if (single && cap_v) begin
                        s_next.st = ST_DONE;
                    end
                end
            end
            default: s_next.st = ST_IDLE;
        endcase
        // Deliver: latch for sampling, else push directly
        if (cap_v && sampled) begin
            s_next.last = cap_d;
            s_next.have_new = 1'b1;
        end else if (cap_v) begin
            push_v = 1'b1;
            push_d = cap_d;
        end
        // Sample edge while running takes the latest capture
        if (sampled && smp_evt &&
            (s_reg.st == ST_WAIT || s_reg.st == ST_MEAS)) begin
            if (s_next.have_new) begin
                push_v = 1'b1;
                push_d = s_next.last;
                s_next.have_new = 1'b0;
            end else begin
                s_next.overrun = 1'b1;
            end
        end
        // A full FIFO drops the capture and says so
        if (push_v && !fifo_wr_ready) begin
            s_next.overflow = 1'b1;
        end
        // Abort wins over the state update; a capture pushed this cycle still lands
        if (disarm_i) begin
            s_next.st = ST_IDLE;
        end
        // Stream output stage
        if (fifo_rd_ready) begin
            s_next.out_valid = fifo_rd_valid;
            if (fifo_rd_valid) begin
                s_next.out_data = fifo_rd_data;
            end
        end
        // Status flags registered from the next state
        s_next.armed = (s_next.st == ST_WAIT) || (s_next.st == ST_MEAS);
        s_next.done = (s_next.st == ST_DONE);
    end

    // State register
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    // Outputs straight from flip-flops
    assign stream_valid_o = s_reg.out_valid;
    assign stream_data_o = s_reg.out_data;
    assign count_o = s_reg.cnt;
    assign armed_o = s_reg.armed;
    assign done_o = s_reg.done;
    assign overrun_o = s_reg.overrun;
    assign overflow_o = s_reg.overflow;
    assign cfg_err_o = s_reg.cfg_err;

    // Checks on the channel behaviour
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);

    // Waiting without an entry edge never starts counting
    property p_wait_needs_edge;
        s_reg.st == ST_WAIT && !start_edge && !disarm_i
            |=> s_reg.st == ST_WAIT;
    endproperty
    a_wait_needs_edge: assert property (p_wait_needs_edge)
        else $error("Measurement started without entry edge");
    // A tick inside an interval adds exactly one
    property p_tick_adds_one;
        s_reg.st == ST_MEAS && tick_evt && !end_edge && !disarm_i &&
        (eff_meas != MEAS_WIDTH || act)
            |=> s_reg.cnt == $past(s_reg.cnt) + CNT_W'(1);
    endproperty
    a_tick_adds_one: assert property (p_tick_adds_one)
        else $error("Tick did not advance the count by one");
    // Each interval starts from zero
    property p_start_clears;
        s_reg.st == ST_WAIT && start_edge |=> s_reg.cnt == '0;
    endproperty
    a_start_clears: assert property (p_start_clears)
        else $error("Interval did not start from zero");
    // Single width ends in the finished state and stays there
    property p_single_done;
        s_reg.st == ST_MEAS && single && eff_meas == MEAS_WIDTH &&
        leave_act && !disarm_i
            |=> s_reg.st == ST_DONE ##1 (s_reg.st == ST_DONE || $past(arm_i)
                                        || $past(disarm_i));
    endproperty
    a_single_done: assert property (p_single_done)
        else $error("Single width did not finish");
    // Implicit width pushes on each trailing edge
    property p_implicit_push;
        s_reg.st == ST_MEAS && eff_meas == MEAS_WIDTH &&
        timing_mode_i == TIM_IMPLICIT && leave_act
            |-> push_v && push_d == {{(SMP_W-CNT_W){1'b0}}, s_reg.cnt};
    endproperty
    a_implicit_push: assert property (p_implicit_push)
        else $error("Trailing edge without capture push");
    // Sample edge with nothing fresh raises overrun
    property p_overrun;
        sampled && smp_evt && !cap_v && !s_reg.have_new &&
        (s_reg.st == ST_WAIT || s_reg.st == ST_MEAS)
            |=> s_reg.overrun;
    endproperty
    a_overrun: assert property (p_overrun)
        else $error("Missing pulse did not flag overrun");
    // Pulse samples are pairs, semi samples are not
    property p_pairing;
        push_v |-> push_d[SMP_PAIR_BIT] == (eff_meas == MEAS_PULSE);
    endproperty
    a_pairing: assert property (p_pairing)
        else $error("Sample pairing does not match mode");
    // Semi-period with sampled timing is refused
    property p_semi_refused;
        (s_reg.st == ST_IDLE || s_reg.st == ST_DONE) && arm_i && bad_cfg
            |=> s_reg.cfg_err && !armed_o;
    endproperty
    a_semi_refused: assert property (p_semi_refused)
        else $error("Sampled semi-period was not refused");
    // Stream word holds until taken
    property p_stream_hold;
        stream_valid_o && !stream_ready_i
            |=> stream_valid_o && $stable(stream_data_o);
    endproperty
    a_stream_hold: assert property (p_stream_hold)
        else $error("Stream word changed before acceptance");
    // Main scenarios reached
    c_single_width: cover property (s_reg.st == ST_MEAS && single &&
                                    leave_act ##1 done_o);
    c_pulse_pair: cover property (push_v && push_d[SMP_PAIR_BIT]);
    c_overrun: cover property (!overrun_o ##1 overrun_o);
    c_stream: cover property (stream_valid_o && stream_ready_i);
endmodule

// >>> src/gim_pkg.sv
// Shared constants and types for the gate interval measurement counter.
// Assumes one core clock; window, tick and sample pins are asynchronous.
package gim_pkg;
    // Measurement counter width
    localparam int CNT_W = 32;
    // Sample word: paired flag, high count, low count
    localparam int SMP_W = 2 * CNT_W + 1;
    localparam int SMP_HI_LSB = CNT_W;
    localparam int SMP_PAIR_BIT = 2 * CNT_W;
    // Capture FIFO geometry
    localparam int FIFO_DEPTH = 16;
    localparam int FIFO_AW = 4;
    // Core clock and nominal onboard reference rates
    localparam int CORE_CLK_HZ = 125_000_000;
    localparam int TB_FAST_HZ = 80_000_000;
    localparam int TB_MID_HZ = 20_000_000;
    localparam int TB_SLOW_HZ = 100_000;
    // Fastest tick the synchroniser can resolve without loss
    localparam int MAX_TICK_HZ = CORE_CLK_HZ / 4;
    // Pin positions inside the synchroniser vectors
    localparam int PIN_WIN = 0;
    localparam int PIN_TICK = 1;
    localparam int PIN_SMP = 2;
    localparam int PIN_N = 3;

    // What the channel measures
    typedef enum logic [1:0] {
        MEAS_WIDTH,
        MEAS_PULSE,
        MEAS_SEMI,
        MEAS_PERIOD
    } gim_meas_t;

    // How captures are delivered
    typedef enum logic [1:0] {
        TIM_SINGLE,
        TIM_IMPLICIT,
        TIM_SAMPLED
    } gim_timing_t;

    // Channel sequencing
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_WAIT,
        ST_MEAS,
        ST_DONE
    } gim_state_t;
endpackage

// >>> src/gim_fifo.sv
// Capture FIFO of the measurement counter.
// Assumes writer and reader share the core clock.
module gim_fifo
    import gim_pkg::*;
(
    input logic core_clk_i,
    input logic rst_i,
    input logic wr_valid_i,
    input logic [SMP_W-1:0] wr_data_i,
    output logic wr_ready_o,
    output logic rd_valid_o,
    output logic [SMP_W-1:0] rd_data_o,
    input logic rd_ready_i
);
    // All FIFO state
    typedef struct packed {
        logic [FIFO_DEPTH-1:0][SMP_W-1:0] mem;
        logic [FIFO_AW-1:0] wptr;
        logic [FIFO_AW-1:0] rptr;
        logic [FIFO_AW:0] fill;
    } gim_fifo_t;

    gim_fifo_t f_reg;
    gim_fifo_t f_next;
    logic do_wr;
    logic do_rd;

    // Honest full and empty flags
    assign wr_ready_o = (f_reg.fill != (FIFO_AW + 1)'(FIFO_DEPTH));
    assign rd_valid_o = (f_reg.fill != '0);
    assign rd_data_o = f_reg.mem[f_reg.rptr];
    assign do_wr = wr_valid_i && wr_ready_o;
    assign do_rd = rd_ready_i && rd_valid_o;

    // Pointer and fill update
    always_comb begin
        f_next = f_reg;
        if (do_wr) begin
            f_next.mem[f_reg.wptr] = wr_data_i;
            f_next.wptr = f_reg.wptr + FIFO_AW'(1);
        end
        if (do_rd) begin
            f_next.rptr = f_reg.rptr + FIFO_AW'(1);
        end
        if (do_wr && !do_rd) begin
            f_next.fill = f_reg.fill + (FIFO_AW + 1)'(1);
        end else if (do_rd && !do_wr) begin
            f_next.fill = f_reg.fill - (FIFO_AW + 1)'(1);
        end
    end

    // State register
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            f_reg <= '0;
        end else begin
            f_reg <= f_next;
        end
    end
endmodule

// >>> verification/gim_ref_model.sv
// Far-side model: free-running reference tick and gate waveform.
// Assumes the core clock; the tick holds each level TICK_HALF cycles.
module gim_ref_model
#(
    parameter int TICK_HALF = 4
)
(
    input wire logic core_clk_i,
    input wire logic rst_i,
    output logic ref_tick_o,
    output logic window_o
);
    timeunit 1ns;
    timeprecision 1ps;

    int div_reg; // Half-period divider

    initial window_o = 1'b0;

    // Known-rate timebase, runs free outside reset
    always @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            div_reg <= 0;
            ref_tick_o <= 1'b0;
        end else if (div_reg == TICK_HALF - 1) begin
            div_reg <= 0;
            ref_tick_o <= ~ref_tick_o;
        end else begin
            div_reg <= div_reg + 1;
        end
    end

    // Gate level spanning n rising and n falling ticks; the change lands
    // midway between tick edges so neither tick polarity coincides with it
    task automatic hold(input logic lvl, input int n);
        @(negedge ref_tick_o);
        repeat (TICK_HALF / 2) @(posedge core_clk_i);
        window_o <= lvl;
        repeat (n) @(posedge ref_tick_o);
    endtask
endmodule

// >>> verification/tb_top.sv
// Self-checking bench for the gate interval measurement counter.
// Assumes gim_ref_model drives the gate and reference tick pins.
module tb_top
    import gim_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk = 1'b0; // Core clock
    logic rst = 1'b1; // Reset, active high
    logic arm = 1'b0; // Control pulses
    logic disarm = 1'b0;
    logic clr = 1'b0;
    logic smp = 1'b0; // Sample clock pin
    logic rdy = 1'b0; // Stream ready
    logic act_low = 1'b0; // Configuration
    logic fps = 1'b0;
    logic fips = 1'b0;
    logic tfall = 1'b0; // Tick and sample edge polarity
    logic sfall = 1'b0;
    logic stall = 1'b0; // Holds the host off
    gim_meas_t meas = MEAS_WIDTH;
    gim_timing_t tim = TIM_SINGLE;
    logic win, tick; // From the far-side model
    logic vld, armed, done, ovr, ovf, cerr; // Status outputs
    logic [SMP_W-1:0] data; // Stream word
    logic [CNT_W-1:0] cnt; // Live counter
    logic [SMP_W-1:0] got_q[$], exp_q[$]; // Seen and expected words
    int fail_count = 0;
    int n_tests = 0;
    int cyc = 0; // Cycle count for the hang limit

    gim_ref_model u_ref (
        .core_clk_i(clk),
        .rst_i(rst),
        .ref_tick_o(tick),
        .window_o(win)
    );

    gim_counter i_gim_counter (
        .core_clk_i(clk),
        .rst_i(rst),
        .window_i(win),
        .ref_tick_i(tick),
        .sample_clk_i(smp),
        .arm_i(arm),
        .disarm_i(disarm),
        .measure_mode_i(meas),
        .timing_mode_i(tim),
        .window_active_low_i(act_low),
        .tick_falling_i(tfall),
        .sample_falling_i(sfall),
        .first_phase_select_i(fps),
        .first_interval_phase_select_i(fips),
        .clear_errors_i(clr),
        .stream_ready_i(rdy),
        .stream_valid_o(vld),
        .stream_data_o(data),
        .count_o(cnt),
        .armed_o(armed),
        .done_o(done),
        .overrun_o(ovr),
        .overflow_o(ovf),
        .cfg_err_o(cerr)
    );

    always #4 clk = ~clk;

    // Random host stalls and stream capture
    always @(posedge clk) begin
        rdy <= !stall && ($urandom % 4) != 0;
        if (vld === 1'b1 && rdy === 1'b1)
            got_q.push_back(data);
    end

    // Hang limit
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            fail_count++;
            report_and_stop();
        end
    end

    // Expected unpaired and paired words
    function automatic logic [SMP_W-1:0] one_w(int n);
        return SMP_W'(n);
    endfunction

    function automatic logic [SMP_W-1:0] pair_w(int h, int l);
        return {1'b1, CNT_W'(h), CNT_W'(l)};
    endfunction

    task automatic check_flag(logic got, logic exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: flag %b not %b", $time, got, exp);
        end
    endtask

    task automatic check_word(logic [SMP_W-1:0] got, logic [SMP_W-1:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: word %h not %h", $time, got, exp);
        end
    endtask

    // Wait for the expected words, then compare count and contents
    task automatic drain();
        int i;
        i = 0;
        while (got_q.size() < exp_q.size() && i < 600) begin
            @(posedge clk);
            i++;
        end
        repeat (30) @(posedge clk);
        @(negedge clk);
        check_flag(got_q.size() == exp_q.size(), 1'b1);
        while (exp_q.size() > 0 && got_q.size() > 0)
            check_word(got_q.pop_front(), exp_q.pop_front());
        exp_q.delete();
    endtask

    // Abort, reconfigure and flush
    task automatic setup(gim_meas_t m, gim_timing_t t, logic al, logic fp,
                         logic fi);
        @(posedge clk);
        disarm <= 1'b1;
        meas <= m;
        tim <= t;
        act_low <= al;
        fps <= fp;
        fips <= fi;
        @(posedge clk);
        disarm <= 1'b0;
        repeat (4) @(posedge clk);
        got_q.delete();
    endtask

    task automatic arm_pulse();
        @(posedge clk) arm <= 1'b1;
        @(posedge clk) arm <= 1'b0;
        @(posedge clk);
    endtask

    task automatic sample();
        @(posedge clk) smp <= 1'b1;
        repeat (4) @(posedge clk);
        smp <= 1'b0;
        repeat (4) @(posedge clk);
        @(negedge clk);
    endtask

    task automatic report_and_stop();
        if (fail_count == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Main sequence
    initial begin
        int unsigned s;
        int a, b;
        logic f;
        s = $urandom(32'h44210c11);
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        check_flag(|{vld, cnt, armed, done, ovr, ovf, cerr}, 1'b0);
        // Single width, both polarities, armed mid-pulse
        for (int p = 0; p < 2; p++) begin
            f = (p == 0);
            setup(MEAS_WIDTH, TIM_SINGLE, !f, 1'b0, 1'b0);
            a = $urandom_range(12, 1);
            u_ref.hold(f, 3);
            arm_pulse();
            u_ref.hold(f, 3);
            u_ref.hold(!f, 2);
            u_ref.hold(f, a);
            u_ref.hold(!f, 2);
            u_ref.hold(f, 3);
            u_ref.hold(!f, 2);
            exp_q.push_back(one_w(a));
            drain();
            check_flag(done, 1'b1);
            check_flag(cnt == '0, 1'b1);
        end
        // Implicit width, back-to-back pulses
        setup(MEAS_WIDTH, TIM_IMPLICIT, 1'b0, 1'b0, 1'b0);
        u_ref.hold(1'b0, 2);
        arm_pulse();
        for (int i = 0; i < 6; i++) begin
            a = $urandom_range(12, 1);
            u_ref.hold(1'b1, a);
            u_ref.hold(1'b0, 1 + i % 3);
            exp_q.push_back(one_w(a));
        end
        drain();
        // Implicit pulse and semi-period, both starting phases
        for (int p = 0; p < 4; p++) begin
            f = p[0];
            tfall <= f;
            setup(gim_meas_t'(p < 2 ? 1 : 2), TIM_IMPLICIT, 1'b0, f, f);
            u_ref.hold(!f, 2);
            arm_pulse();
            for (int i = 0; i < 3; i++) begin
                a = $urandom_range(12, 1);
                b = $urandom_range(12, 1);
                u_ref.hold(f, a);
                u_ref.hold(!f, b);
                if (p >= 2) begin
                    exp_q.push_back(one_w(a));
                    exp_q.push_back(one_w(b));
                end else begin
                    exp_q.push_back(f ? pair_w(a, b) : pair_w(b, a));
                end
            end
            u_ref.hold(f, 2);
            drain();
        end
        // Stalled host: FIFO fills, later captures are dropped
        setup(MEAS_SEMI, TIM_IMPLICIT, 1'b0, 1'b0, 1'b0);
        stall <= 1'b1;
        u_ref.hold(1'b1, 2);
        arm_pulse();
        for (int i = 0; i < 21; i++) begin
            u_ref.hold(i[0], 1);
            if (i > 0 && i < 18)
                exp_q.push_back(one_w(1));
        end
        @(negedge clk);
        check_flag(ovf, 1'b1);
        stall <= 1'b0;
        drain();
        // Single semi-period, single period and single pulse pair
        for (int p = 0; p < 3; p++) begin
            setup(p == 2 ? MEAS_PULSE : gim_meas_t'(2 + p), TIM_SINGLE,
                  1'b0, 1'b1, 1'b0);
            u_ref.hold(1'b0, 2);
            arm_pulse();
            a = $urandom_range(12, 1);
            b = $urandom_range(12, 1);
            u_ref.hold(1'b1, a);
            u_ref.hold(1'b0, b);
            u_ref.hold(1'b1, 3);
            u_ref.hold(1'b0, 2);
            u_ref.hold(1'b1, 2);
            exp_q.push_back(p == 2 ? pair_w(a, b)
                                   : one_w(p == 0 ? a : a + b));
            drain();
            check_flag(done, 1'b1);
        end
        // Sample-clocked width and pulse, then overrun and clear
        for (int p = 0; p < 2; p++) begin
            sfall <= p[0];
            setup(gim_meas_t'(p), TIM_SAMPLED, 1'b0, 1'b1, 1'b0);
            u_ref.hold(1'b0, 2);
            arm_pulse();
            a = $urandom_range(12, 1);
            b = $urandom_range(12, 1);
            u_ref.hold(1'b1, a);
            u_ref.hold(1'b0, b);
            u_ref.hold(1'b1, 1);
            sample();
            exp_q.push_back(p == 0 ? one_w(a) : pair_w(a, b));
            drain();
            check_flag(ovr, 1'b0);
            sample();
            check_flag(ovr, 1'b1);
            @(posedge clk) clr <= 1'b1;
            @(posedge clk) clr <= 1'b0;
            @(negedge clk);
            check_flag(ovr, 1'b0);
        end
        // Sample clocking refused for semi-period
        setup(MEAS_SEMI, TIM_SAMPLED, 1'b0, 1'b0, 1'b0);
        arm_pulse();
        @(negedge clk);
        check_flag(cerr, 1'b1);
        check_flag(armed, 1'b0);
        report_and_stop();
    end
endmodule
